// *** osc_out_regs.vh ***
`ifndef OSC_OUT_REGS_VH
`define OSC_OUT_REGS_VH

// ****************************************
// Timing and widths
// ****************************************
`define START_CYCLES 500
`define CODE_LATENCY_CYCLES 500
`define FILTER_CYCLES 16
`define PRESCALE_RATIO 1024
`define PRESCALE_BITS 10
`define SEL_BITS 21
`define CODE_BITS 4
`endif

// *** code_filter.v ***
`timescale 1ns/100ps
`include "osc_out_regs.vh"
module code_filter #(
	parameter STABLE_CYCLES = `FILTER_CYCLES
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_b,
	// Raw code
	input wire [3:0] i_code,
	// Confirmed code
	output reg [3:0] o_code,
	output reg o_valid
);
	reg [3:0] last;
	reg [7:0] count;

	// ****************************************
	// Stability filter
	// ****************************************
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			last <= 4'h0;
			count <= 8'h00;
			o_code <= 4'h0;
			o_valid <= 1'b0;
		end else if (i_code != last) begin
			last <= i_code;
			count <= 8'h00;
		end else if (count < STABLE_CYCLES[7:0]) begin
			count <= count + 8'h01;
		end else begin
			o_code <= last;
			o_valid <= 1'b1;
		end
	end
endmodule

// *** osc_out.v ***
`timescale 1ns/100ps
`include "osc_out_regs.vh"
module osc_out #(
	parameter START_CYCLES = `START_CYCLES
) (
	// Clock and power-on reset
	input wire i_clk,
	input wire i_rst_b,
	// Pins
	input wire [3:0] i_divider_select_code,
	input wire i_output_reset,
	output reg o_out,
	// Status
	output reg o_output_polarity_select
);
	wire [3:0] code;
	wire code_ok;
	reg [`PRESCALE_BITS-1:0] prescale;
	reg [`SEL_BITS-1:0] divider;
	reg [8:0] start_count;
	reg started;
	reg started_d;
	reg [`SEL_BITS:0] one_hot;
	wire rst_mid_active;
	reg latch;
	reg rst_s1;
	reg rst_s2;
	reg [2:0] ratio_idx;
	reg half_tick;
	reg [`SEL_BITS-1:0] half_mask;
	reg next_out;
	wire pre_tick;
	wire rst_active;
	wire rst_raw_active;

	code_filter #(
		.STABLE_CYCLES(`FILTER_CYCLES)
	) u_filter (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_code(i_divider_select_code),
		.o_code(code),
		.o_valid(code_ok)
	);

	// ****************************************
	// Divider chain, free running
	// ****************************************
	assign pre_tick = (prescale == `PRESCALE_RATIO - 1);
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			prescale <= {`PRESCALE_BITS{1'b0}};
			divider <= {`SEL_BITS{1'b0}};
		end else begin
			prescale <= prescale + 1'b1;
			if (pre_tick)
				divider <= divider + 1'b1;
		end
	end

	// Code to ratio, mirrored about midpoint
	always @* begin
		ratio_idx = code[3] ? ~code[2:0] : code[2:0];
		one_hot = {{`SEL_BITS{1'b0}}, 1'b1} << (3 * ratio_idx);
		half_mask = one_hot[`SEL_BITS:1];
		// Half-period boundary: prescale wraps and low divider bits all set; at ratio 0, every prescale wrap and midpoint
		if (ratio_idx == 3'h0)
			half_tick = (prescale == (`PRESCALE_RATIO / 2 - 1)) || pre_tick;
		else
			half_tick = pre_tick && ((divider & (half_mask - 1'b1)) == (half_mask - 1'b1));
	end

	// ****************************************
	// Reset input synchroniser
	// ****************************************
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= i_output_reset;
			rst_s2 <= rst_s1;
		end
	end
	assign rst_active = rst_s2 ^ o_output_polarity_select;
	assign rst_raw_active = i_output_reset ^ o_output_polarity_select;
	// Bridges raw and synced paths so a short reset leaves no sliver
	assign rst_mid_active = rst_s1 ^ o_output_polarity_select;

	// ****************************************
	// Start-up interval
	// ****************************************
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			start_count <= 9'h000;
			started <= 1'b0;
			started_d <= 1'b0;
			o_output_polarity_select <= 1'b0;
		end else begin
			started_d <= started;
			if (start_count < START_CYCLES[8:0])
				start_count <= start_count + 9'h001;
			else if (code_ok)
				started <= 1'b1;
			if (code_ok)
				o_output_polarity_select <= code[3];
		end
	end

	// ****************************************
	// Output latch and buffer
	// ****************************************
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			latch <= 1'b0;
		end else if (!started || rst_active) begin
			latch <= 1'b0;
		end else if (!started_d && o_output_polarity_select) begin
			// Inverted start: active level after one master period
			latch <= 1'b1;
		end else if (half_tick) begin
			latch <= ~latch;
		end
	end

	always @* begin
		if (!started)
			next_out = 1'b0;
		else if (rst_raw_active || rst_mid_active || rst_active)
			next_out = o_output_polarity_select;
		else
			next_out = latch ^ o_output_polarity_select;
	end

	always @(posedge i_clk) begin
		if (!i_rst_b)
			o_out <= 1'b0;
		else
			o_out <= next_out;
	end
endmodule

// *** osc_out_checker.sv ***
`timescale 1ns/100ps
module osc_out_checker #(
	parameter START_CYCLES = 500
) (
	input wire i_clk,
	input wire i_rst_b,
	input wire [3:0] i_divider_select_code,
	input wire i_output_reset,
	input wire o_out,
	input wire o_output_polarity_select
);
	int cnt;
	wire output_polarity_select = o_output_polarity_select;
	wire rs = i_output_reset;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	always @(posedge i_clk) begin
		if (!i_rst_b) cnt <= 0;
		else if (cnt < START_CYCLES + 50) cnt <= cnt + 1;
	end
	chk_start_low: assert property (cnt < START_CYCLES |-> !o_out) else $error("start");
	chk_por_clear: assert property ($past(!i_rst_b) |-> !o_out && !output_polarity_select) else $error("por");
	chk_pol0_hold: assert property (!output_polarity_select && rs |=> !o_out || output_polarity_select) else $error("rst0");
	chk_pol1_hold: assert property (cnt > START_CYCLES + 40 && output_polarity_select && !rs ##1 output_polarity_select && !rs
		|-> o_out) else $error("rst1");
	chk_pol_code: assert property ($changed(output_polarity_select) |-> output_polarity_select == i_divider_select_code[3])
		else $error("pol");
	chk_code_settled: assert property ($changed(output_polarity_select) |-> $past(i_divider_select_code, 2)
		== i_divider_select_code) else $error("filt");
	chk_high_width: assert property ($rose(o_out) && !output_polarity_select && !rs |=> o_out || output_polarity_select)
		else $error("hi");
	chk_low_width: assert property ($fell(o_out) && output_polarity_select && rs |=> !o_out || !output_polarity_select)
		else $error("lo");
	cover property ($rose(o_out) && !output_polarity_select);
	cover property ($fell(o_out) && output_polarity_select);
	cover property ($changed(output_polarity_select));
endmodule
bind osc_out osc_out_checker #(.START_CYCLES(START_CYCLES)) osc_out_checker_i (.i_clk(i_clk),
	.i_rst_b(i_rst_b), .i_divider_select_code(i_divider_select_code),
	.i_output_reset(i_output_reset), .o_out(o_out),
	.o_output_polarity_select(o_output_polarity_select));

// *** reset_source.sv ***
`timescale 1ns/100ps
module reset_source (
	input wire i_clk,
	input wire i_level,
	output reg o_output_reset
);
	always @(posedge i_clk) o_output_reset <= i_level;
endmodule

// *** resettable_divided_oscillator_output_tb.sv ***
`timescale 1ns/100ps
module resettable_divided_oscillator_output_tb;
	logic i_clk = 1'h0;
	logic i_rst_b = 1'h0;
	logic [3:0] code = 4'h0;
	logic lvl = 1'h0;
	wire rst_pin;
	wire o_out;
	wire output_polarity_select;
	int err_total = 0;
	int checks_done = 0;
	int n;
	always #4 i_clk = ~i_clk;
	reset_source reset_source_i (.i_clk(i_clk), .i_level(lvl), .o_output_reset(rst_pin));
	osc_out #(.START_CYCLES(20)) osc_out_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_divider_select_code(code), .i_output_reset(rst_pin), .o_out(o_out),
		.o_output_polarity_select(output_polarity_select));
	task ck(input logic [31:0] a, input logic [31:0] e);
		checks_done++;
		if (a !== e) begin
			err_total++;
			$display("Error %0t %h %h", $time, a, e);
		end
	endtask
	task wt(input logic v);
		n = 0;
		while (o_out !== v && n < 5000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (o_out !== v) ck(o_out, v);
	endtask
	task t_start1;
		@(posedge i_clk);
		i_rst_b <= 1'h0;
		lvl <= 1'h1;
		code <= 4'hf;
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'h1;
		wt(1'h1);
		ck(n >= 20, 1'h1);
		@(posedge i_clk);
		#1;
		ck(o_out, 1'h0);
	endtask
	task t_run;
		wt(1'h1);
		ck(n >= 20, 1'h1);
		wt(1'h0);
		ck(n, 512);
	endtask
	task t_pol0;
		@(posedge i_clk);
		lvl <= 1'h1;
		repeat (600) @(posedge i_clk);
		#1;
		ck(o_out, 1'h0);
		@(posedge i_clk);
		lvl <= 1'h0;
		wt(1'h1);
		ck(n <= 1024, 1'h1);
	endtask
	task t_pol1;
		@(posedge i_clk);
		code <= 4'hf;
		n = 0;
		while (output_polarity_select !== 1'h1 && n < 600) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		ck(n < 500, 1'h1);
		repeat (4) @(posedge i_clk);
		#1;
		ck(o_out, 1'h1);
		@(posedge i_clk);
		lvl <= 1'h1;
		wt(1'h0);
		ck(n <= 1024, 1'h1);
		wt(1'h1);
		ck(n, 512);
	endtask
	task t_codes;
		for (int c = 0; c < 16; c++) begin
			@(posedge i_clk);
			code <= c[3:0];
			repeat (60) @(posedge i_clk);
			#1;
			ck(output_polarity_select, c[3]);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'h1;
		t_run;
		t_pol0;
		t_pol1;
		t_codes;
		t_start1;
		report_and_stop;
	end
	initial begin
		#200000;
		err_total++;
		report_and_stop;
	end
endmodule
